// File: fan_cruise_pkg.sv
// Overview of operation
// - config bits 7-5 read PWM pin levels
// - bits 3-2 pick manual, thermal or speed
// - config bit 0 selects push-pull, else open-drain
// - too hot: step duty up to FFh
// - speed mode: steer duty to target count
// - tolerance bits 7-5 read tach pin levels, 0 where general input is not selected
// - thermal mode: bits 3-0 are temperature band
// - speed mode: bits 3-0 are count band
// - thermal mode: at or below stop duty, duty becomes zero
// - thermal mode: from zero, jump to start-up duty
// - thermal mode: wait stop time before stop to zero
// - step-up interval between duty increments
// - smart modes read back live duty
// - thermal mode: miss flag after 3 minutes full speed while too hot
package fan_cruise_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] STEP_UP_TIME_IDX = 8'h8F;
	localparam logic [7:0] DUTY_IDX         = 8'h94;
	localparam logic [7:0] CONFIG_IDX       = 8'h95;
	localparam logic [7:0] TARGET_IDX       = 8'h96;
	localparam logic [7:0] TOLERANCE_IDX    = 8'h97;
	localparam logic [7:0] STOP_DUTY_IDX    = 8'h98;
	localparam logic [7:0] STARTUP_DUTY_IDX = 8'h99;
	localparam logic [7:0] STOP_TIME_IDX    = 8'h9A;
	localparam logic [7:0] STATUS_IDX       = 8'h9B;

	// reset values
	localparam logic [7:0] STEP_UP_TIME_RST = 8'h0A;
	localparam logic [7:0] DUTY_RST         = 8'hFF;
	localparam logic [7:0] CONFIG_RST       = 8'h00;
	localparam logic [7:0] TARGET_RST       = 8'h00;
	localparam logic [7:0] TOLERANCE_RST    = 8'h00;
	localparam logic [7:0] STOP_DUTY_RST    = 8'h01;
	localparam logic [7:0] STARTUP_DUTY_RST = 8'h01;
	localparam logic [7:0] STOP_TIME_RST    = 8'h3C;

	// field positions
	localparam int CFG_PWM_C_LVL_BIT  = 7;
	localparam int CFG_PWM_B_LVL_BIT  = 6;
	localparam int CFG_PWM_A_LVL_BIT  = 5;
	localparam int CFG_TYPE_LSB       = 2;
	localparam int CFG_PUSH_PULL_BIT  = 0;
	localparam int TOL_TACH_C_LVL_BIT = 7;
	localparam int TOL_TACH_B_LVL_BIT = 6;
	localparam int TOL_TACH_A_LVL_BIT = 5;
	localparam int STATUS_MISS_BIT    = 2;

	localparam logic [7:0] DUTY_FULL = 8'hFF;

	// timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int TICK_PERIOD_NS  = 100_000_000;
	localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int MISS_TIME_MIN   = 3;
	// divide first: the full product would overflow a 32-bit int
	localparam int MISS_TICKS      = MISS_TIME_MIN * 60 * (1_000_000_000 / TICK_PERIOD_NS);
	localparam int PWM_PRESCALE    = 1;

	typedef enum logic [1:0] {
		MODE_MANUAL,
		MODE_THERMAL,
		MODE_SPEED,
		MODE_RESERVED
	} ctrl_mode_t;

endpackage : fan_cruise_pkg

// File: fan_drive_if.sv
interface fan_drive_if;
	logic [7:0] duty;
	logic       push_pull;
	logic       pin_out;
	logic       pin_oe;

	modport ctrl (output duty, output push_pull, input pin_out, input pin_oe);
	modport pwm  (input duty, input push_pull, output pin_out, output pin_oe);
endinterface : fan_drive_if

// File: pwm_waveform.sv
module pwm_waveform
	import fan_cruise_pkg::*;
#(
	parameter int PRESCALE = PWM_PRESCALE
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// drive request and pin
	fan_drive_if.pwm  drv
);

	localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

	logic [PW-1:0] pre_cnt;
	logic [7:0]    phase;
	logic          step_en;
	logic          level;

	assign step_en = (pre_cnt == PW'(PRESCALE - 1));
	// FFh holds the line high for the whole period
	assign level   = (drv.duty == DUTY_FULL) || (phase < drv.duty);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_cnt <= '0;
			phase   <= 8'h00;
		end else begin
			pre_cnt <= step_en ? '0 : pre_cnt + PW'(1);
			if (step_en)
				phase <= phase + 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			drv.pin_out <= 1'b0;
			drv.pin_oe  <= 1'b0;
		end else if (drv.push_pull) begin
			drv.pin_out <= level;
			drv.pin_oe  <= 1'b1;
		end else begin
			// open drain: pull low only, let the line float high
			drv.pin_out <= 1'b0;
			drv.pin_oe  <= !level;
		end
	end

endmodule : pwm_waveform

// File: fan_cruise_ctrl.sv
// Decided for this implementation: register access over APB.
module fan_cruise_ctrl
	import fan_cruise_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int MISS_TK  = MISS_TICKS,
	parameter int PRESCALE = PWM_PRESCALE
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// measurements
	input  wire logic [7:0]  temperature_input_c_i,
	input  wire logic [7:0]  tach_count_c_i,
	// general input pins
	input  wire logic        pwm_pin_a_level_i,
	input  wire logic        pwm_pin_b_level_i,
	input  wire logic        pwm_pin_c_level_i,
	input  wire logic        tach_pin_a_level_i,
	input  wire logic        tach_pin_b_level_i,
	input  wire logic        tach_pin_c_level_i,
	input  wire logic        tach_a_general_input_select_i,
	input  wire logic        tach_b_general_input_select_i,
	input  wire logic        tach_c_general_input_select_i,
	// fan pwm pin and miss flag
	output logic             fan_c_pwm_pin_o,
	output logic             fan_c_pwm_pin_oe_o,
	output logic             target_temp_c_miss_flag_o
);

	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int MW = $clog2(MISS_TK + 1);

	// software registers
	logic [7:0] step_up_time;
	logic [7:0] fan_c_duty;
	logic [1:0] fan_c_control_type;
	logic       cfg_reserved_bit;
	logic       fan_c_push_pull_enable;
	logic [7:0] target_reg;
	logic [3:0] tolerance;
	logic [7:0] fan_c_stop_duty;
	logic [7:0] fan_c_startup_duty;
	logic [7:0] fan_c_stop_time;
	logic       target_temp_c_miss_flag;

	// controller state
	logic [7:0]    smart_duty;
	logic [TW-1:0] tick_cnt;
	logic [7:0]    step_cnt;
	logic [7:0]    stop_cnt;
	logic [MW-1:0] miss_cnt;

	// bus decode
	wire        setup_ph  = psel_i && !penable_i;
	wire        access_ph = psel_i && penable_i;
	wire        aligned   = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
	wire [7:0]  reg_idx   = paddr_i[9:2];
	wire        hit_step  = aligned && (reg_idx == STEP_UP_TIME_IDX);
	wire        hit_duty  = aligned && (reg_idx == DUTY_IDX);
	wire        hit_cfg   = aligned && (reg_idx == CONFIG_IDX);
	wire        hit_tgt   = aligned && (reg_idx == TARGET_IDX);
	wire        hit_tol   = aligned && (reg_idx == TOLERANCE_IDX);
	wire        hit_stop  = aligned && (reg_idx == STOP_DUTY_IDX);
	wire        hit_start = aligned && (reg_idx == STARTUP_DUTY_IDX);
	wire        hit_stime = aligned && (reg_idx == STOP_TIME_IDX);
	wire        hit_stat  = aligned && (reg_idx == STATUS_IDX);
	wire        mapped    = hit_step || hit_duty || hit_cfg || hit_tgt || hit_tol
	                        || hit_stop || hit_start || hit_stime || hit_stat;
	wire        wr_en     = access_ph && pwrite_i && mapped;
	wire        stat_rd   = access_ph && !pwrite_i && hit_stat;
	wire [7:0]  wbyte     = pwdata_i[7:0];

	assign pready_o  = 1'b1;
	assign pslverr_o = access_ph && !mapped;

	// mode and comparisons
	ctrl_mode_t mode;
	assign mode = ctrl_mode_t'(fan_c_control_type);

	wire        thermal   = (mode == MODE_THERMAL);
	wire        speed     = (mode == MODE_SPEED);
	wire        smart     = thermal || speed;
	wire [6:0]  fan_c_target_temperature = target_reg[6:0];
	wire [7:0]  fan_c_target_count       = target_reg;
	wire [3:0]  fan_c_temp_tolerance     = tolerance;
	wire [3:0]  fan_c_speed_tolerance    = tolerance;
	wire [8:0]  temp_hi   = {2'b00, fan_c_target_temperature} + {5'h00, fan_c_temp_tolerance};
	wire [8:0]  temp_meas = {1'b0, temperature_input_c_i};
	wire [8:0]  temp_lo_m = temp_meas + {5'h00, fan_c_temp_tolerance};
	wire        too_hot   = temp_meas > temp_hi;
	wire        too_cold  = temp_lo_m < {2'b00, fan_c_target_temperature};
	wire [8:0]  cnt_hi    = {1'b0, fan_c_target_count} + {5'h00, fan_c_speed_tolerance};
	wire [8:0]  cnt_meas  = {1'b0, tach_count_c_i};
	wire [8:0]  cnt_lo_m  = cnt_meas + {5'h00, fan_c_speed_tolerance};
	// a larger count means a slower fan
	wire        too_slow  = cnt_meas > cnt_hi;
	wire        too_fast  = cnt_lo_m < {1'b0, fan_c_target_count};

	// 0.1 s tick
	wire        tick      = (tick_cnt == TW'(TICK_CYC - 1));
	wire [7:0]  step_len  = (step_up_time == 8'h00) ? 8'h01 : step_up_time;
	wire        step_due  = tick && (step_cnt + 8'h01 >= step_len);
	wire        at_full   = (smart_duty == DUTY_FULL);
	wire        at_zero   = (smart_duty == 8'h00);
	wire        at_floor  = !at_zero && (smart_duty <= fan_c_stop_duty);
	wire        stop_done = tick && (stop_cnt + 8'h01 >= fan_c_stop_time);
	wire        miss_hit  = thermal && at_full && too_hot && tick
	                        && (miss_cnt == MW'(MISS_TK - 1));
	wire [7:0]  live_duty = smart ? smart_duty : fan_c_duty;

	// read data
	wire [7:0]  cfg_rd    = {pwm_pin_c_level_i, pwm_pin_b_level_i, pwm_pin_a_level_i,
	                         1'b0, fan_c_control_type, cfg_reserved_bit,
	                         fan_c_push_pull_enable};
	wire        tach_c_lv = tach_c_general_input_select_i && tach_pin_c_level_i;
	wire        tach_b_lv = tach_b_general_input_select_i && tach_pin_b_level_i;
	wire        tach_a_lv = tach_a_general_input_select_i && tach_pin_a_level_i;
	wire [7:0]  tol_rd    = {tach_c_lv, tach_b_lv, tach_a_lv, 1'b0, tolerance};
	wire [7:0]  stat_rd_v = {5'h00, target_temp_c_miss_flag, 2'b00};
	wire [7:0]  rd_byte   = hit_step  ? step_up_time :
	                        hit_duty  ? live_duty :
	                        hit_cfg   ? cfg_rd :
	                        hit_tgt   ? target_reg :
	                        hit_tol   ? tol_rd :
	                        hit_stop  ? fan_c_stop_duty :
	                        hit_start ? fan_c_startup_duty :
	                        hit_stime ? fan_c_stop_time :
	                        hit_stat  ? stat_rd_v : 8'h00;

	// next smart duty
	logic [7:0] next_smart_duty;
	logic       step_taken;
	logic       in_stop_wait;

	always_comb begin
		next_smart_duty = smart_duty;
		step_taken      = 1'b0;
		in_stop_wait    = 1'b0;
		unique case (mode)
			MODE_THERMAL: begin
				if (too_hot) begin
					if (at_zero && tick) begin
						next_smart_duty = fan_c_startup_duty;
						step_taken      = 1'b1;
					end else if (step_due && !at_full) begin
						next_smart_duty = smart_duty + 8'h01;
						step_taken      = 1'b1;
					end
				end else if (too_cold && !at_zero) begin
					if (at_floor) begin
						in_stop_wait = 1'b1;
						if (stop_done)
							next_smart_duty = 8'h00;
					end else if (step_due) begin
						step_taken = 1'b1;
						// never rest between stop duty and zero
						if (smart_duty - 8'h01 < fan_c_stop_duty)
							next_smart_duty = fan_c_stop_duty;
						else
							next_smart_duty = smart_duty - 8'h01;
					end
				end
			end
			MODE_SPEED: begin
				if (step_due && too_slow && !at_full) begin
					next_smart_duty = smart_duty + 8'h01;
					step_taken      = 1'b1;
				end else if (step_due && too_fast && !at_zero) begin
					next_smart_duty = smart_duty - 8'h01;
					step_taken      = 1'b1;
				end
			end
			MODE_MANUAL,
			MODE_RESERVED: begin
				// track the written duty so a mode change starts smoothly
				next_smart_duty = fan_c_duty;
			end
		endcase
	end

	// register writes
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			step_up_time           <= STEP_UP_TIME_RST;
			fan_c_duty             <= DUTY_RST;
			fan_c_control_type     <= CONFIG_RST[CFG_TYPE_LSB +: 2];
			cfg_reserved_bit       <= CONFIG_RST[1];
			fan_c_push_pull_enable <= CONFIG_RST[CFG_PUSH_PULL_BIT];
			target_reg             <= TARGET_RST;
			tolerance              <= TOLERANCE_RST[3:0];
			fan_c_stop_duty        <= STOP_DUTY_RST;
			fan_c_startup_duty     <= STARTUP_DUTY_RST;
			fan_c_stop_time        <= STOP_TIME_RST;
		end else if (wr_en) begin
			if (hit_step)
				step_up_time <= wbyte;
			if (hit_duty)
				fan_c_duty <= wbyte;
			if (hit_cfg) begin
				fan_c_control_type     <= wbyte[CFG_TYPE_LSB +: 2];
				cfg_reserved_bit       <= wbyte[1];
				fan_c_push_pull_enable <= wbyte[CFG_PUSH_PULL_BIT];
			end
			if (hit_tgt)
				target_reg <= wbyte;
			if (hit_tol)
				tolerance <= wbyte[3:0];
			if (hit_stop)
				fan_c_stop_duty <= wbyte;
			if (hit_start)
				fan_c_startup_duty <= wbyte;
			if (hit_stime)
				fan_c_stop_time <= wbyte;
		end
	end

	// read data captured in the setup phase
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			prdata_o <= 32'h0000_0000;
		else if (setup_ph && !pwrite_i)
			prdata_o <= {24'h00_0000, rd_byte};
	end

	// tick and interval counters
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			tick_cnt <= '0;
		else
			tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			step_cnt <= 8'h00;
		else if (!smart || step_taken)
			step_cnt <= 8'h00;
		else if (tick && !step_due)
			step_cnt <= step_cnt + 8'h01;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			stop_cnt <= 8'h00;
		else if (!in_stop_wait || stop_done)
			stop_cnt <= 8'h00;
		else if (tick)
			stop_cnt <= stop_cnt + 8'h01;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			smart_duty <= DUTY_RST;
		else
			smart_duty <= next_smart_duty;
	end

	// full-speed watchdog
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			miss_cnt <= '0;
		else if (!(thermal && at_full && too_hot) || miss_hit)
			miss_cnt <= '0;
		else if (tick)
			miss_cnt <= miss_cnt + MW'(1);
	end

	// set wins over the clear by read
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			target_temp_c_miss_flag <= 1'b0;
		else if (miss_hit)
			target_temp_c_miss_flag <= 1'b1;
		else if (stat_rd)
			target_temp_c_miss_flag <= 1'b0;
	end

	assign target_temp_c_miss_flag_o = target_temp_c_miss_flag;

	// pwm output
	fan_drive_if drv ();

	assign drv.duty      = live_duty;
	assign drv.push_pull = fan_c_push_pull_enable;

	pwm_waveform #(
		.PRESCALE (PRESCALE)
	) u_pwm (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.drv    (drv)
	);

	assign fan_c_pwm_pin_o    = drv.pin_out;
	assign fan_c_pwm_pin_oe_o = drv.pin_oe;

endmodule : fan_cruise_ctrl

// File: fan_cruise_props.sv
module fan_cruise_props
	import fan_cruise_pkg::*;
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        nrst_i,
	// apb
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// pin levels
	input wire logic        pwm_pin_a_level_i,
	input wire logic        pwm_pin_b_level_i,
	input wire logic        pwm_pin_c_level_i,
	input wire logic        tach_pin_a_level_i,
	input wire logic        tach_pin_b_level_i,
	input wire logic        tach_pin_c_level_i,
	input wire logic        tach_a_general_input_select_i,
	input wire logic        tach_b_general_input_select_i,
	input wire logic        tach_c_general_input_select_i,
	// outputs
	input wire logic        fan_c_pwm_pin_o,
	input wire logic        fan_c_pwm_pin_oe_o,
	input wire logic        target_temp_c_miss_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] pwm_q;
	logic [2:0] tach_q;
	// levels as seen at the read setup edge
	always_ff @(posedge clk_i) begin
		pwm_q  <= {pwm_pin_c_level_i, pwm_pin_b_level_i, pwm_pin_a_level_i};
		tach_q <= {tach_pin_c_level_i & tach_c_general_input_select_i,
			tach_pin_b_level_i & tach_b_general_input_select_i,
			tach_pin_a_level_i & tach_a_general_input_select_i};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence access;
		psel_i && penable_i;
	endsequence
	sequence rd_setup(logic [7:0] idx);
		psel_i && !penable_i && !pwrite_i && paddr_i == {2'b00, idx, 2'b00};
	endsequence
	ready_now_a: assert property (access |-> pready_o) else $error("pready low");
	align_err_a: assert property (access ##0 paddr_i[1:0] != 2'h0 |-> pslverr_o)
		else $error("no error on misaligned access");
	range_err_a: assert property (access ##0 paddr_i[11:10] != 2'h0 |-> pslverr_o)
		else $error("no error on out of range access");
	err_idle_a: assert property (!penable_i |-> !pslverr_o) else $error("stray pslverr");
	rd_hold_a: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
		else $error("read data moved");
	pwm_lvl_a: assert property (rd_setup(CONFIG_IDX) |=> prdata_o[7:5] == pwm_q)
		else $error("pwm pin levels wrong");
	tach_lvl_a: assert property (rd_setup(TOLERANCE_IDX) |=> prdata_o[7:5] == tach_q)
		else $error("tach pin levels wrong");
	od_low_a: assert property (!fan_c_pwm_pin_oe_o |-> !fan_c_pwm_pin_o)
		else $error("undriven pin carries high");
	flag_clr_a: assert property ($fell(target_temp_c_miss_flag_o) |-> $past(penable_i)
		&& !$past(pwrite_i) && $past(paddr_i) == {2'b00, STATUS_IDX, 2'b00})
		else $error("flag cleared without status read");
endmodule : fan_cruise_props

// File: fan_model.sv
module fan_model (
	// clock and pin
	input  wire logic       clk_i,
	input  wire logic       pin_i,
	input  wire logic       oe_i,
	// line and speed
	output logic            line_o,
	output logic      [7:0] count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] phase;
	logic [7:0] highs;
	// pull-up holds the line high while undriven
	assign line_o = oe_i ? pin_i : 1'b1;
	initial begin
		phase = 8'h00;
		highs = 8'h00;
		count_o = 8'hFF;
	end
	// speed settles once per 256-clock window, so it answers slowly
	always @(posedge clk_i) begin
		phase <= phase + 8'h01;
		highs <= (phase == 8'hFF) ? 8'h00 : highs + {7'h00, line_o};
		if (phase == 8'hFF) begin
			count_o <= ~highs;
		end
	end
endmodule : fan_model

// File: fan_cruise_ctrl_tb.sv
module fan_cruise_ctrl_tb
	import fan_cruise_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 20;
	localparam int MK = 5;
	logic        clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [7:0]  temp_i, count_c;
	logic [1:0]  pwm_ab;
	logic [2:0]  tach_lvl, tach_sel;
	logic        line_c, pin_o, oe_o, flag_o, err;
	int          bad_count, n_tests;

	fan_cruise_ctrl #(.TICK_CYC(TK), .MISS_TK(MK), .PRESCALE(1)) dut_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.temperature_input_c_i(temp_i), .tach_count_c_i(count_c),
		.pwm_pin_a_level_i(pwm_ab[0]), .pwm_pin_b_level_i(pwm_ab[1]),
		.pwm_pin_c_level_i(line_c), .tach_pin_a_level_i(tach_lvl[0]),
		.tach_pin_b_level_i(tach_lvl[1]), .tach_pin_c_level_i(tach_lvl[2]),
		.tach_a_general_input_select_i(tach_sel[0]),
		.tach_b_general_input_select_i(tach_sel[1]),
		.tach_c_general_input_select_i(tach_sel[2]), .fan_c_pwm_pin_o(pin_o),
		.fan_c_pwm_pin_oe_o(oe_o), .target_temp_c_miss_flag_o(flag_o));
	fan_model fan_u (.clk_i(clk_i), .pin_i(pin_o), .oe_i(oe_o), .line_o(line_c),
		.count_o(count_c));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] x = 4'h0);
		@(posedge clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= {x[3:2], idx, x[1:0]};
		pwdata_i <= {24'h0, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		// a high pready_o ends this wait; the watchdog only catches a stall
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr
	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp});
	endtask : rdc
	task automatic wait_rd(input logic [7:0] v, input int lim);
		int n;
		n = 0;
		do begin
			apb(1'b0, DUTY_IDX, 8'h00);
			n++;
		end while (rd[7:0] !== v && n < lim);
	endtask : wait_rd
	// reads spaced by a whole number of ticks
	task automatic step_chk(input int ticks, input logic [7:0] delta);
		logic [7:0] first;
		apb(1'b0, DUTY_IDX, 8'h00);
		first = rd[7:0];
		repeat (ticks * TK - 3) @(posedge clk_i);
		apb(1'b0, DUTY_IDX, 8'h00);
		chk(rd, {24'h0, first + delta});
	endtask : step_chk

	task automatic t_reset();
		logic [7:0] ix [9] = '{8'h8F, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B};
		logic [7:0] ex [9] = '{8'h0A, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h3C, 8'h00};
		for (int i = 0; i < 9; i++) begin
			rdc(ix[i], ex[i]);
		end
		apb(1'b0, 8'h90, 8'h00);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b0, CONFIG_IDX, 8'h00, 4'h1);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, CONFIG_IDX, 8'hFF, 4'h8);
		rdc(CONFIG_IDX, 8'h80);
		$display("reset test done");
	endtask : t_reset

	task automatic t_regs();
		logic [7:0] ix [5] = '{8'h8F, 8'h96, 8'h98, 8'h99, 8'h9A};
		logic [7:0] v [5] = '{8'h07, 8'hA5, 8'h5A, 8'hC3, 8'h7E};
		for (int i = 0; i < 5; i++) begin
			wr(ix[i], v[i]);
			rdc(ix[i], v[i]);
		end
		wr(TOLERANCE_IDX, 8'hFF);
		rdc(TOLERANCE_IDX, 8'h0F);
		wr(CONFIG_IDX, 8'h1E);
		rdc(CONFIG_IDX, 8'h8E);
		wr(DUTY_IDX, 8'h33);
		rdc(DUTY_IDX, 8'h33);
		wr(DUTY_IDX, 8'hFF);
		wr(CONFIG_IDX, 8'h00);
		for (int i = 0; i < 8; i++) begin
			tach_lvl <= 3'h7;
			tach_sel <= i[2:0];
			pwm_ab   <= i[1:0];
			rdc(TOLERANCE_IDX, {i[2:0], 5'h0F});
			rdc(CONFIG_IDX, {1'b1, i[1:0], 5'h00});
		end
		$display("register test done");
	endtask : t_regs

	task automatic t_drive();
		logic [7:0] cf [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
		logic [7:0] dt [4] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
		logic [1:0] ex [4] = '{2'b00, 2'b11, 2'b10, 2'b10};
		for (int i = 0; i < 4; i++) begin
			wr(CONFIG_IDX, cf[i]);
			wr(DUTY_IDX, dt[i]);
			repeat (3) @(posedge clk_i);
			chk({30'h0, oe_o, pin_o}, {30'h0, ex[i]});
		end
		$display("drive test done");
	endtask : t_drive

	task automatic t_thermal();
		wr(STOP_DUTY_IDX, 8'h10);
		wr(STARTUP_DUTY_IDX, 8'h40);
		wr(STEP_UP_TIME_IDX, 8'h01);
		wr(STOP_TIME_IDX, 8'h03);
		wr(TARGET_IDX, 8'h1E);
		wr(TOLERANCE_IDX, 8'h02);
		temp_i <= 8'h21;
		wr(CONFIG_IDX, 8'h04);
		wait_rd(8'h40, 20);
		chk(rd, 32'h40);
		step_chk(2, 8'h02);
		wr(STEP_UP_TIME_IDX, 8'h02);
		step_chk(4, 8'h02);
		temp_i <= 8'h20;
		repeat (TK) @(posedge clk_i);
		step_chk(2, 8'h00);
		wr(STEP_UP_TIME_IDX, 8'h01);
		temp_i <= 8'h1B;
		wait_rd(8'h10, 600);
		chk(rd, 32'h10);
		repeat (TK - 3) @(posedge clk_i);
		rdc(DUTY_IDX, 8'h10);
		repeat (5 * TK) @(posedge clk_i);
		rdc(DUTY_IDX, 8'h00);
		temp_i <= 8'h21;
		wait_rd(8'h40, 20);
		chk(rd, 32'h40);
		$display("thermal test done");
	endtask : t_thermal

	task automatic t_miss();
		wr(CONFIG_IDX, 8'h00);
		wr(DUTY_IDX, 8'hFF);
		wr(CONFIG_IDX, 8'h04);
		repeat (3 * TK) @(posedge clk_i);
		chk({31'h0, flag_o}, 32'h0);
		repeat ((MK + 2) * TK) @(posedge clk_i);
		chk({31'h0, flag_o}, 32'h1);
		wr(CONFIG_IDX, 8'h00);
		rdc(STATUS_IDX, 8'h04);
		rdc(STATUS_IDX, 8'h00);
		$display("miss flag test done");
	endtask : t_miss

	task automatic t_speed();
		wr(DUTY_IDX, 8'h20);
		wr(TARGET_IDX, 8'h80);
		wr(TOLERANCE_IDX, 8'h02);
		// let the fan model report the new duty before tracking starts
		repeat (512) @(posedge clk_i);
		wr(CONFIG_IDX, 8'h08);
		repeat (10 * TK) @(posedge clk_i);
		apb(1'b0, DUTY_IDX, 8'h00);
		chk({31'h0, rd[7:0] > 8'h20}, 32'h1);
		repeat (250 * TK) @(posedge clk_i);
		apb(1'b0, DUTY_IDX, 8'h00);
		chk({31'h0, rd[7:0] > 8'h60 && rd[7:0] < 8'hA0}, 32'h1);
		$display("speed test done");
	endtask : t_speed

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{temp_i, pwm_ab, tach_lvl, tach_sel} = '0;
		bad_count = 0;
		n_tests = 0;
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_regs();
		t_drive();
		t_thermal();
		t_miss();
		t_speed();
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		wrap_up();
	end
endmodule : fan_cruise_ctrl_tb

bind fan_cruise_ctrl fan_cruise_props props_u (.*);
